// ### include/fmr_pkg.sv
/*
  Constants and carrier types of the FM register, phase and operator core.
  Assumes one 250 MHz clock and 32-bit APB with byte addresses.
*/
package fmr_pkg;
  // ******************************
  // apb map, byte addresses
  // ******************************
  localparam logic [11:0] OFS_LOC = 12'h000;
  localparam logic [11:0] OFS_DATA = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam int STAT_BUSY_BIT = 7;
  localparam logic [6:0] BUSY_CYC = 7'h44;

  // ******************************
  // parameter store layout
  // ******************************
  localparam logic [7:0] LOC_TRIG = 8'h08;
  localparam logic [7:0] LOC_AUX = 8'h1B;
  localparam logic [7:0] LOC_VOICE = 8'h20;
  localparam logic [7:0] LOC_PITCH = 8'h28;
  localparam logic [7:0] LOC_FRAC = 8'h30;
  localparam logic [7:0] LOC_VIB = 8'h38;
  localparam logic [7:0] LOC_RATIO = 8'h40;
  localparam logic [7:0] LOC_COARSE = 8'hC0;
  localparam int AUX_A_BIT = 6;
  localparam int AUX_B_BIT = 7;
  localparam int TRIG_MASK_LSB = 3;
  localparam int FRAC_LSB = 2;
  localparam int VIB_LSB = 4;
  localparam int FB_LSB = 3;
  localparam int FINE_LSB = 4;
  localparam int COARSE_LSB = 6;

  // ******************************
  // pitch and wave tables
  // ******************************
  localparam int OCT_SPAN = 768;
  localparam int STEP_SPAN = 64;
  localparam int PITCH_MAX = 6143;
  localparam int TOP_OCT = 7;
  localparam int MOD_SHIFT = 3;
  // top-octave increments of the twelve semitones plus the next octave step
  localparam logic [220:0] BASE_TBL = {17'h144C8, 17'h1328E, 17'h12159,
    17'h1111C, 17'h101C8, 17'h0F350, 17'h0E5A8, 17'h0D8C4, 17'h0CC9A,
    17'h0C11E, 17'h0B647, 17'h0AC0C, 17'h0A264};
  // coarse offsets in 1/64 semitone steps
  localparam logic [39:0] COARSE_TBL = {10'h260, 10'h1F4, 10'h180, 10'h000};
  // quarter sine, 32 points, full scale 4095
  localparam logic [383:0] SINE_TBL = {12'hFFE, 12'hFF4, 12'hFE0, 12'hFC3,
    12'hF9C, 12'hF6B, 12'hF30, 12'hEED, 12'hEA0, 12'hE4A, 12'hDEB, 12'hD84,
    12'hD14, 12'hC9C, 12'hC1D, 12'hB96, 12'hB08, 12'hA73, 12'h9D7, 12'h936,
    12'h88F, 12'h7E2, 12'h731, 12'h67B, 12'h5C2, 12'h505, 12'h444, 12'h381,
    12'h2BC, 12'h1F5, 12'h12D, 12'h065};

  // ******************************
  // carrier types
  // ******************************
  typedef enum logic {WR_IDLE, WR_WAIT} fmr_wr_t;
  typedef struct packed {
    logic [4:0] slot;
    logic key_on;
  } fmr_slot_t;
  typedef struct packed {
    logic valid;
    logic [2:0] voice;
    logic signed [14:0] sample;
  } fmr_voice_out_t;
endpackage

// ### hdl/fmr_core.sv
/*
  FM core: APB parameter store with write-pending status, aux pins,
  note trigger, 32-slot phase generator and operator stage.
  Assumes the envelope value for the shown slot arrives on env_atten and
  the LFO pitch signal on lfo_pm; both are sampled synchronously.
*/
`timescale 1ns/100ps
module fmr_core
  import fmr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic initial_clear_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [7:0] lfo_pm,
  input wire logic [9:0] env_atten,
  output fmr_slot_t slot_info,
  output fmr_voice_out_t voice_out,
  output logic aux_output_pin_a,
  output logic aux_output_pin_b
);
  // ******************************
  // functions
  // ******************************
  // offsets that answer on the bus
  function automatic logic fmr_hit(input logic [11:0] a);
    return (a == OFS_LOC) || (a == OFS_DATA) || (a == OFS_STAT);
  endfunction
  // phase step of one operator from its pitch settings
  function automatic logic [19:0] fmr_inc(input logic [6:0] pc, input logic [5:0] fr,
    input logic signed [10:0] vib, input logic [1:0] cd, input logic [2:0] fd,
    input logic [3:0] mr);
    int k, p, oc, f, b0, b1, v, d;
    // semitone codes skip every fourth value; the clamp catches the unused top code
    k = int'(pc[3:0]) - int'(pc[3:2]);
    k = (k > 11) ? 11 : k;
    p = int'(pc[6:4]) * OCT_SPAN + k * STEP_SPAN + int'(fr) + int'(vib)
      + int'(COARSE_TBL[int'(cd) * 10 +: 10]);
    p = (p < 0) ? 0 : (p > PITCH_MAX) ? PITCH_MAX : p;
    oc = p / OCT_SPAN;
    k = (p % OCT_SPAN) / STEP_SPAN;
    f = p % STEP_SPAN;
    b0 = int'(BASE_TBL[k * 17 +: 17]);
    b1 = int'(BASE_TBL[(k + 1) * 17 +: 17]);
    v = (b0 + ((b1 - b0) * f) / STEP_SPAN) >> (TOP_OCT - oc);
    d = int'(fd[1:0]) * (oc + 1);
    v = fd[2] ? v - d : v + d;
    v = (mr == 4'h0) ? v / 2 : v * int'(mr); // ratio zero means one half
    return v[19:0];
  endfunction
  // ******************************
  // bus slave
  // ******************************
  logic [7:0] loc_q, data_q;
  logic [7:0] store_q [256];
  logic [6:0] busy_cnt_q;
  logic [31:0] prdata_q;
  fmr_wr_t wr_q;
  logic busy, wr_go, setup, commit;
  // zero-wait slave; an unmapped offset answers with an error
  assign setup = psel & ~penable;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~fmr_hit(paddr);
  assign prdata = prdata_q;
  assign wr_go = psel & penable & pwrite & (paddr == OFS_DATA);
  assign busy = (busy_cnt_q != 7'h00);
  assign commit = (busy_cnt_q == 7'h01);
  // read data is chosen in the setup cycle so it stands in the access cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        OFS_LOC: prdata_q <= {24'h000000, loc_q};
        OFS_DATA: prdata_q <= {24'h000000, data_q};
        OFS_STAT: prdata_q <= 32'(busy) << STAT_BUSY_BIT;
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // location first, then data; the data write launches the store update
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loc_q <= 8'h00;
      data_q <= 8'h00;
    end else if (psel && penable && pwrite) begin
      if (paddr == OFS_LOC) begin
        loc_q <= pwdata[7:0];
      end else if (paddr == OFS_DATA) begin
        data_q <= pwdata[7:0];
      end
    end
  end

  // pending-write timer; a new data byte restarts it, older data is lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_q <= 7'h00;
      wr_q <= WR_IDLE;
    end else if (wr_go) begin
      busy_cnt_q <= BUSY_CYC;
      wr_q <= WR_WAIT;
    end else if (busy) begin
      busy_cnt_q <= busy_cnt_q - 7'h01;
      wr_q <= commit ? WR_IDLE : WR_WAIT;
    end
  end

  // parameter store; clear holds every byte at zero and drops commits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      store_q <= '{default: 8'h00};
    end else if (!initial_clear_n) begin
      store_q <= '{default: 8'h00};
    end else if (commit && wr_q == WR_WAIT) begin
      store_q[loc_q] <= data_q;
    end
  end
  // aux pins follow their store bits, so clear drives them low
  assign aux_output_pin_a = store_q[LOC_AUX][AUX_A_BIT];
  assign aux_output_pin_b = store_q[LOC_AUX][AUX_B_BIT];
  // ******************************
  // slot sequencer and note trigger
  // ******************************
  logic sub_q, trig_go;
  logic [4:0] slot_q;
  logic [31:0] key_q;
  logic [2:0] voice;
  logic [1:0] op;

  assign trig_go = commit && wr_q == WR_WAIT && initial_clear_n && loc_q == LOC_TRIG;
  assign voice = slot_q[4:2];
  assign op = slot_q[1:0];
  assign slot_info = '{slot: slot_q, key_on: key_q[slot_q]};

  // two clocks per slot, 64 per sample, as the pitch tables expect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sub_q <= 1'b0;
      slot_q <= 5'h00;
    end else begin
      sub_q <= ~sub_q;
      if (sub_q) begin
        slot_q <= slot_q + 5'h01;
      end
    end
  end

  // slot of voice v, operator i is 4*v+i in the trigger bit order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_q <= 32'h0000_0000;
    end else if (!initial_clear_n) begin
      key_q <= 32'h0000_0000;
    end else if (trig_go) begin
      for (int i = 0; i < 4; i++) begin
        key_q[{data_q[2:0], 2'(i)}] <= data_q[TRIG_MASK_LSB + i];
      end
    end
  end

  // ******************************
  // phase generator
  // ******************************
  logic [19:0] phase_q [32];
  logic [19:0] inc, phase_next;
  logic [7:0] vcfg, scfg;
  logic signed [10:0] vib;
  logic [2:0] vsens;

  assign vcfg = store_q[LOC_VOICE + {5'h00, voice}];
  assign scfg = store_q[LOC_RATIO + {3'h0, slot_q}];
  assign vsens = store_q[LOC_VIB + {5'h00, voice}][VIB_LSB +: 3];

  // vibrato depth doubles per step of the sensitivity
  always_comb begin
    int g;
    g = (vsens == 3'h0) ? 0 : (1 << (int'(vsens) - 1));
    vib = 11'((int'(lfo_pm) * g) >>> 4);
  end

  assign inc = fmr_inc(store_q[LOC_PITCH + {5'h00, voice}][6:0],
    store_q[LOC_FRAC + {5'h00, voice}][FRAC_LSB +: 6], vib,
    store_q[LOC_COARSE + {3'h0, slot_q}][COARSE_LSB +: 2],
    scfg[FINE_LSB +: 3], scfg[3:0]);
  assign phase_next = phase_q[slot_q] + inc;
  // starting an operator restarts its phase; otherwise step once per slot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= '{default: 20'h00000};
    end else begin
      if (sub_q) begin
        phase_q[slot_q] <= phase_next;
      end
      if (trig_go) begin
        for (int i = 0; i < 4; i++) begin
          if (data_q[TRIG_MASK_LSB + i] && !key_q[{data_q[2:0], 2'(i)}]) begin
            phase_q[{data_q[2:0], 2'(i)}] <= 20'h00000;
          end
        end
      end
    end
  end
  // ******************************
  // operator stage
  // ******************************
  logic signed [12:0] opout_q [3];
  logic signed [12:0] m1a_q, m1b_q, amp;
  logic signed [14:0] modsum, vsum;
  logic [2:0] msel, alg, fb;
  logic [3:0] osel;
  logic [9:0] ph;
  fmr_voice_out_t vout_q;

  assign alg = vcfg[2:0];
  assign fb = vcfg[FB_LSB +: 3];

  // which earlier operators modulate this one, customary wiring
  always_comb begin
    msel = 3'h0;
    osel = 4'h8;
    unique case (op)
      2'h0: msel = 3'h0;
      2'h1: msel = (alg inside {3'h0, 3'h3, 3'h4, 3'h5, 3'h6}) ? 3'h1 : 3'h0;
      2'h2: msel = (alg == 3'h1) ? 3'h3 : (alg inside {3'h0, 3'h2}) ? 3'h2 : (alg == 3'h5) ? 3'h1 : 3'h0;
      2'h3: msel = (alg inside {3'h0, 3'h1, 3'h4}) ? 3'h4 : (alg == 3'h2) ? 3'h5
        : (alg == 3'h3) ? 3'h6 : (alg == 3'h5) ? 3'h1 : 3'h0;
    endcase
    unique case (alg)
      3'h4: osel = 4'hA;
      3'h5, 3'h6: osel = 4'hE;
      3'h7: osel = 4'hF;
      default: osel = 4'h8;
    endcase
  end

  // modulation sum; the first operator hears the last two first-operator outputs, those of the two previous voices
  always_comb begin
    modsum = 15'sh0000;
    for (int i = 0; i < 3; i++) begin
      if (msel[i]) begin
        modsum = modsum + 15'(opout_q[i]);
      end
    end
    modsum = (op == 2'h0 && fb != 3'h0) ? 15'((15'(m1a_q) + 15'(m1b_q)) >>> (4'hA - {1'b0, fb}))
      : modsum >>> MOD_SHIFT;
    ph = phase_q[slot_q][19:10] + modsum[9:0];
  end

  // quarter table folded out to a full wave, then scaled by envelope
  always_comb begin
    logic [4:0] idx;
    logic signed [12:0] s;
    logic [10:0] gain;
    idx = ph[8] ? ~ph[7:3] : ph[7:3];
    s = signed'({1'b0, SINE_TBL[int'(idx) * 12 +: 12]});
    s = ph[9] ? -s : s;
    gain = 11'h3FF - {1'b0, env_atten};
    amp = 13'((24'(s) * signed'(24'(gain))) >>> 10);
  end

  // voice mix of the carriers once the fourth operator is done
  always_comb begin
    vsum = osel[3] ? 15'(amp) : 15'sh0000;
    for (int i = 0; i < 3; i++) begin
      if (osel[i]) begin
        vsum = vsum + 15'(opout_q[i]);
      end
    end
  end
  // per-voice operator outputs, reused by the later operators of the voice
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opout_q <= '{default: 13'sh0000};
    end else if (sub_q && op != 2'h3) begin
      opout_q[op] <= amp;
    end
  end
  // feedback history is one pair shared by all voices, area traded against per-voice copies
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m1a_q <= 13'sh0000;
      m1b_q <= 13'sh0000;
    end else if (sub_q && op == 2'h0) begin
      m1a_q <= amp;
      m1b_q <= m1a_q;
    end
  end

  // one-cycle sample pulse toward the output summer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vout_q <= '0;
    end else begin
      vout_q.valid <= sub_q && op == 2'h3;
      vout_q.voice <= voice;
      vout_q.sample <= vsum;
    end
  end
  assign voice_out = vout_q;
  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_busy_run;
    busy ##67 busy;
  endsequence
  a_busy_span: assert property (wr_go && !busy |-> ##1 s_busy_run ##1 !busy)
    else $error("write pending flag span wrong");
  a_clear_zero: assert property (!initial_clear_n |=> store_q[LOC_TRIG] == 8'h00)
    else $error("store not cleared");
  a_aux_clear: assert property (!initial_clear_n |=> !aux_output_pin_a && !aux_output_pin_b)
    else $error("aux pins not low under clear");
  a_store_commit: assert property (commit && wr_q == WR_WAIT && initial_clear_n
    |=> store_q[$past(loc_q)] == $past(data_q)) else $error("store byte not written");
  a_trig_first: assert property (trig_go
    |=> key_q[{$past(data_q[2:0]), 2'h0}] == $past(data_q[TRIG_MASK_LSB])) else $error("trigger bit order wrong");
  a_slot_wrap: assert property (slot_q == 5'h1F && sub_q |=> slot_q == 5'h00 ##2 slot_q == 5'h01)
    else $error("slot walk broken");
  a_voice_pulse: assert property (voice_out.valid |-> $past(op) == 2'h3 && !sub_q)
    else $error("voice sample at wrong slot");
  a_phase_step: assert property (sub_q && !trig_go
    |=> phase_q[$past(slot_q)] == $past(phase_next)) else $error("phase not stepped");
  a_tone_ref: assert property (fmr_inc(7'h4A, 6'h00, 11'sh000, 2'h0, 3'h0, 4'h1) == 20'h02039)
    else $error("reference pitch step wrong");
endmodule

// ### verif/fmr_host_model.sv
/*
  host model: an apb master that writes the parameter store and polls busy.
  assumes one clock; every change lands just after a rising edge.
*/
`timescale 1ns/100ps
module fmr_host_model
  import fmr_pkg::*;
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ******************************
  // bus cycles
  // ******************************
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // one transfer; only the bench timeout ends the wait for pready
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep the last value
    paddr <= ~a;
    pwdata <= ~wd;
  endtask

  // poll until the internal write has finished
  task automatic wait_idle();
    logic [31:0] r;
    logic e;
    apb_xfer(1'b0, OFS_STAT, 32'h00000000, r, e);
    while (r[STAT_BUSY_BIT] !== 1'b0) apb_xfer(1'b0, OFS_STAT, 32'h00000000, r, e);
  endtask

  // location first, then data, then wait so the next data never races the write
  task automatic write_param(input logic [7:0] loc, input logic [7:0] dat);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, OFS_LOC, {24'h000000, loc}, r, e);
    apb_xfer(1'b1, OFS_DATA, {24'h000000, dat}, r, e);
    wait_idle();
  endtask
endmodule

// ### verif/fmr_core_tb_top.sv
/*
  self-checking bench of the fm core: busy timing, aux pins, initial clear,
  note trigger per slot, slot walk, voice pulses and silent envelope.
  assumes the host model drives apb; lfo and envelope inputs are random.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((exp) !== (got)) begin n_mismatch++; \
  $display("unexpected %s: expected %0h, seen %0h", nm, exp, got); end end
module fmr_core_tb_top
  import fmr_pkg::*;
;
  // ******************************
  // signals and instances
  // ******************************
  logic clk, nrst, initial_clear_n, psel, penable, pwrite, pready, pslverr, err, env_max;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [7:0] lfo_pm;
  logic [9:0] env_atten;
  logic [31:0] key_model;
  logic [7:0] val;
  logic [3:0] mask;
  fmr_slot_t slot_info;
  fmr_voice_out_t voice_out;
  logic aux_output_pin_a, aux_output_pin_b;
  int n_mismatch, comparisons, cycles, dly;
  integer seed = 32'h99c02fa3;

  fmr_core u_dut (.clk(clk), .nrst(nrst), .initial_clear_n(initial_clear_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lfo_pm(lfo_pm), .env_atten(env_atten),
    .slot_info(slot_info), .voice_out(voice_out), .aux_output_pin_a(aux_output_pin_a),
    .aux_output_pin_b(aux_output_pin_b));
  fmr_host_model u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 250 mhz clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // random lfo and envelope; full attenuation on demand to silence every slot
  always @(posedge clk) begin
    lfo_pm <= 8'($random(seed));
    env_atten <= env_max ? 10'h3FF : 10'($random(seed));
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ******************************
  // shared tasks
  // ******************************
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one sample period: slot walk, key bits, voice pulses
  task automatic sweep();
    int nv;
    int nch;
    logic [7:0] seen;
    logic [4:0] last;
    nv = 0;
    nch = 0;
    seen = 8'h00;
    @(negedge clk);
    last = slot_info.slot;
    repeat (64) begin
      @(negedge clk);
      `CHK("key_on", key_model[slot_info.slot], slot_info.key_on)
      if (slot_info.slot !== last) begin
        nch++;
        `CHK("slot step", 5'(last + 5'h01), slot_info.slot)
      end
      last = slot_info.slot;
      if (voice_out.valid === 1'b1) begin
        nv++;
        seen[voice_out.voice] = 1'b1;
        if (env_max) `CHK("silent sample", 15'h0000, voice_out.sample)
      end
    end
    `CHK("slot changes", 32, nch)
    `CHK("voice pulses", 8, nv)
    `CHK("voices seen", 8'hFF, seen)
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    nrst = 1'b0;
    initial_clear_n = 1'b1;
    env_max = 1'b0;
    lfo_pm = 8'h00;
    env_atten = 10'h000;
    key_model = 32'h00000000;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK("aux a at reset", 1'b0, aux_output_pin_a)
    // busy must cover setup cycles 1..68 after the data write and no more
    for (int i = 0; i < 3; i++) begin
      dly = (i == 0) ? 0 : 65 + i;
      val = 8'($random(seed));
      u_host.apb_xfer(1'b1, OFS_LOC, {24'h000000, LOC_AUX}, rd, err);
      u_host.apb_xfer(1'b1, OFS_DATA, {24'h000000, val}, rd, err);
      repeat (dly) @(posedge clk);
      u_host.apb_xfer(1'b0, OFS_STAT, 32'h00000000, rd, err);
      `CHK("busy", {24'h000000, (dly + 2 <= int'(BUSY_CYC)), 7'h00}, rd)
      u_host.wait_idle();
      u_host.apb_xfer(1'b0, OFS_LOC, 32'h00000000, rd, err);
      `CHK("loc readback", {24'h000000, LOC_AUX}, rd)
      `CHK("loc err", 1'b0, err)
      repeat (2) @(negedge clk);
      `CHK("aux a", val[AUX_A_BIT], aux_output_pin_a)
      `CHK("aux b", val[AUX_B_BIT], aux_output_pin_b)
    end
    // unmapped offset is refused and reads zero
    u_host.apb_xfer(1'b0, 12'h00C, 32'h00000000, rd, err);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h00000000, rd)
    `CHK("pready", 1'b1, pready)
    // every voice, with the all-off and all-on masks at the ends
    for (int v = 0; v < 8; v++) begin
      mask = (v == 0) ? 4'h0 : (v == 7) ? 4'hF : 4'($random(seed));
      key_model[v * 4 +: 4] = mask;
      u_host.write_param(LOC_PITCH + 8'(v), 8'($random(seed)) & 8'h7F);
      u_host.write_param(LOC_VOICE + 8'(v), 8'($random(seed)) & 8'h3F);
      u_host.write_param(LOC_TRIG, {1'b0, mask, 3'(v)});
    end
    sweep();
    // full attenuation silences every voice
    env_max = 1'b1;
    repeat (70) @(negedge clk);
    sweep();
    env_max = 1'b0;
    // initial clear wipes aux bits and keys
    u_host.write_param(LOC_AUX, 8'hC0);
    repeat (2) @(negedge clk);
    `CHK("aux a set", 1'b1, aux_output_pin_a)
    `CHK("aux b set", 1'b1, aux_output_pin_b)
    @(posedge clk);
    initial_clear_n <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("aux a in clear", 1'b0, aux_output_pin_a)
    `CHK("aux b in clear", 1'b0, aux_output_pin_b)
    @(posedge clk);
    initial_clear_n <= 1'b1;
    key_model = 32'h00000000;
    sweep();
    complete_run();
  end
endmodule
